// ### hdl/flash_word_pkg.sv
// Purpose : constants shared by the single-word program sequencer
// Assumes : one 200 MHz clock, AHB-Lite register access
// Notes   : register byte offsets and field positions live here only
//
// Summary of operation
// - word program enable set: one write programs exactly one two-byte word
// - table writes land in the holding latch the table pointer selects
// - key 55h then 0AAh, then write start begins the program cycle
// - execution stalls for the whole programming time, resumes on completion
package flash_word_pkg;
  // byte offsets of the registers
  localparam logic [7:0] OFS_TABLE_POINTER = 8'h00;
  localparam logic [7:0] OFS_TABLE_LATCH   = 8'h04;
  localparam logic [7:0] OFS_TABLE_WRITE   = 8'h08;
  localparam logic [7:0] OFS_MEM_CONTROL   = 8'h0C;
  localparam logic [7:0] OFS_UNLOCK_KEY    = 8'h10;
  localparam logic [7:0] OFS_HOLD_DATA     = 8'h14;
  // memory control field positions
  localparam int BIT_WRITE_START  = 0;
  localparam int BIT_MEM_WR_EN    = 1;
  localparam int BIT_WORD_PROG_EN = 2;
  localparam int BIT_WRITE_ERROR  = 3;
  localparam int BIT_BUSY         = 4;
  // unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // widths
  localparam int ADDR_W = 21;
  // programming time, in microseconds, and derived cycle count
  localparam int CLK_MHZ        = 200;
  localparam int T_WORD_PROG_US = 50;
  localparam int PROG_CYCLES    = T_WORD_PROG_US * CLK_MHZ;
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_KEY1, ST_ARMED, ST_PROG} seq_state_t;
endpackage

// ### hdl/flash_prog_if.sv
// Purpose : carries a word program request to the program timer
// Assumes : same clock as the sequencer
// Notes   : start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface flash_prog_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface
`default_nettype wire

// ### hdl/flash_prog_timer.sv
// Purpose : counts the word programming time
// Assumes : start pulse only while idle
// Notes   : stands in for the array's own program pulse
`timescale 1ns/100ps
`default_nettype none
module flash_prog_timer
  import flash_word_pkg::*;
#(
  parameter int CYCLES = PROG_CYCLES
)(
  input  wire logic hclk,    // system clock
  input  wire logic hresetn, // async reset, low
  flash_prog_if.tmr pif      // start and done
);
  typedef struct packed {
    logic        run;
    logic [31:0] cnt;
    logic        done;
  } tmr_t;
  tmr_t s_r, s_nxt;

  // ----------------------------------------
  // countdown
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (pif.start && !s_r.run)
    begin
      s_nxt.run = 1'b1;
      s_nxt.cnt = 32'(CYCLES - 1);
    end
    else if (s_r.run)
    begin
      if (s_r.cnt == 32'h0)
      begin
        s_nxt.run  = 1'b0;
        s_nxt.done = 1'b1;
      end
      else
        s_nxt.cnt = s_r.cnt - 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign pif.done = s_r.done;
endmodule // flash_prog_timer
`default_nettype wire

// ### hdl/flash_ahb_slave.sv
// Purpose : AHB-Lite address phase capture for the sequencer
// Assumes : single word transfers, always OKAY
// Notes   : zero wait states; stall is applied by the top
`timescale 1ns/100ps
`default_nettype none
module flash_ahb_slave (
  input  wire logic        hclk,      // system clock
  input  wire logic        hresetn,   // async reset, low
  input  wire logic        hsel,      // slave select
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write
  input  wire logic [7:0]  haddr,     // low address bits
  input  wire logic        hready,    // bus ready
  output logic             ph_valid,  // data phase pending
  output logic             ph_write,  // pending is write
  output logic [7:0]       ph_addr    // pending address
);
  typedef struct packed {
    logic       v;
    logic       w;
    logic [7:0] a;
  } ph_t;
  ph_t s_r, s_nxt;

  // ----------------------------------------
  // capture on accepted address phase
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    if (hready)
    begin
      s_nxt.v = hsel && htrans[1];
      s_nxt.w = hwrite;
      s_nxt.a = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ph_valid = s_r.v;
  assign ph_write = s_r.w;
  assign ph_addr  = s_r.a;
endmodule // flash_ahb_slave
`default_nettype wire

// ### hdl/flash_word_program_seq.sv
// Purpose : single-word program sequencer behind an AHB-Lite slave
// Assumes : one clock, CPU stalled through cpu_stall while programming
// Notes   : write data of a stalled access is taken after programming ends
`timescale 1ns/100ps
`default_nettype none
module flash_word_program_seq
  import flash_word_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
)(
  input  wire logic        hclk,        // system clock
  input  wire logic        hresetn,     // async reset, low
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write
  input  wire logic [2:0]  hsize,       // size, word only
  input  wire logic [31:0] hwdata,      // write data
  input  wire logic        hready,      // bus ready in
  output logic             hreadyout,   // slave ready
  output logic             hresp,       // always OKAY
  output logic [31:0]      hrdata,      // read data
  output logic             cpu_stall,   // execution stall
  output logic             prog_strobe, // array program pulse
  output logic [ADDR_W-1:0] prog_addr,  // word address programmed
  output logic [15:0]      prog_data    // word programmed
);
  flash_prog_if pif ();

  logic       ph_valid;
  logic       ph_write;
  logic [7:0] ph_addr;

  typedef struct packed {
    seq_state_t        st;
    logic [ADDR_W-1:0] tptr;
    logic [7:0]        tlat;
    logic [7:0]        hold_lo;
    logic [7:0]        hold_hi;
    logic              memory_write_enable;
    logic              word_program_enable;
    logic              werr;
    logic              start;
    logic              stall;
    logic              pstb;
    logic [ADDR_W-1:0] paddr;
    logic [15:0]       pdata;
    logic [31:0]       rdata;
  } seq_t;
  seq_t s_r, s_nxt;

  logic wr_acc;
  logic rd_acc;

  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  flash_ahb_slave u_bus (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .haddr    (haddr[7:0]),
    .hready   (hready),
    .ph_valid (ph_valid),
    .ph_write (ph_write),
    .ph_addr  (ph_addr)
  );

  flash_prog_timer #(
    .CYCLES (PROG_TIME_CYCLES)
  ) u_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pif     (pif)
  );

  // data phase completes only when not stalled
  assign wr_acc = ph_valid && ph_write && !s_r.stall;
  assign rd_acc = ph_valid && !ph_write && !s_r.stall;

  // ----------------------------------------
  // sequencer and register file
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.pstb  = 1'b0;
    // any bus write other than the expected key or an accepted write start breaks the unlock chain
    if (wr_acc && (s_r.st == ST_KEY1 || s_r.st == ST_ARMED))
      s_nxt.st = ST_IDLE;
    if (wr_acc)
    begin
      case (ph_addr)
        OFS_TABLE_POINTER: s_nxt.tptr = hwdata[ADDR_W-1:0];
        OFS_TABLE_LATCH:   s_nxt.tlat = hwdata[7:0];
        OFS_TABLE_WRITE:
        begin
          // low pointer bit picks the latch byte
          if (s_r.tptr[0])
            s_nxt.hold_hi = s_r.tlat;
          else
            s_nxt.hold_lo = s_r.tlat;
          if (hwdata[0])
            s_nxt.tptr = s_r.tptr + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
        OFS_UNLOCK_KEY:
        begin
          if (hwdata[7:0] == KEY_FIRST)
            s_nxt.st = ST_KEY1;
          else if (s_r.st == ST_KEY1 && hwdata[7:0] == KEY_SECOND)
            s_nxt.st = ST_ARMED;
          else
            s_nxt.st = ST_IDLE;
        end
        OFS_MEM_CONTROL:
        begin
          s_nxt.memory_write_enable  = hwdata[BIT_MEM_WR_EN];
          s_nxt.word_program_enable = hwdata[BIT_WORD_PROG_EN];
          if (!hwdata[BIT_WRITE_ERROR])
            s_nxt.werr = 1'b0;
          if (hwdata[BIT_WRITE_START])
          begin
            if (s_r.st == ST_ARMED && hwdata[BIT_MEM_WR_EN] && s_r.memory_write_enable)
            begin
              s_nxt.st    = ST_PROG;
              s_nxt.start = 1'b1;
              s_nxt.stall = 1'b1;
            end
            else
              s_nxt.werr = 1'b1; // refused start is flagged
          end
        end
        default: ;
      endcase
    end
    if (s_r.st == ST_PROG && pif.done)
    begin
      s_nxt.st    = ST_IDLE;
      s_nxt.stall = 1'b0;
      // one two-byte word, never a block
      s_nxt.pstb  = s_r.word_program_enable;
      // word outputs move only with a strobe, so the array never sees a stray word
      if (s_r.word_program_enable)
      begin
        s_nxt.paddr = {s_r.tptr[ADDR_W-1:1], 1'b0};
        s_nxt.pdata = {s_r.hold_hi, s_r.hold_lo};
      end
      else
        s_nxt.werr = 1'b1;
    end
    // read mux, registered into the data phase
    if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        OFS_TABLE_POINTER: s_nxt.rdata = {{(32-ADDR_W){1'b0}}, s_r.tptr};
        OFS_TABLE_LATCH:   s_nxt.rdata = {24'h000000, s_r.tlat};
        OFS_MEM_CONTROL:   s_nxt.rdata = {27'h0000000, s_r.stall, s_r.werr,
                                          s_r.word_program_enable, s_r.memory_write_enable, s_r.stall};
        OFS_HOLD_DATA:     s_nxt.rdata = {16'h0000, s_r.hold_hi, s_r.hold_lo};
        default:           s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pif.start   = s_r.start;
  assign hreadyout   = !s_r.stall;   // stall holds the bus
  assign hresp       = 1'b0;
  assign hrdata      = s_r.rdata;
  assign cpu_stall   = s_r.stall;
  assign prog_strobe = s_r.pstb;
  assign prog_addr   = s_r.paddr;
  assign prog_data   = s_r.pdata;
endmodule // flash_word_program_seq
`default_nettype wire

// ### test/flash_word_program_seq_sva.sv
// Purpose : assertions on the ports of the single-word program sequencer
// Assumes : one clock, reset active low
// Notes   : stall length is counted in helper logic, not unrolled
`timescale 1ns/100ps
`default_nettype none
module flash_word_program_seq_sva
  import flash_word_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
)(
  input wire logic              hclk,        // system clock
  input wire logic              hresetn,     // async reset, low
  input wire logic              hsel,        // slave select
  input wire logic [1:0]        htrans,      // transfer type
  input wire logic              hwrite,      // write
  input wire logic              hready,      // bus ready in
  input wire logic              hreadyout,   // slave ready
  input wire logic              hresp,       // response
  input wire logic [31:0]       hrdata,      // read data
  input wire logic              cpu_stall,   // execution stall
  input wire logic              prog_strobe, // program pulse
  input wire logic [ADDR_W-1:0] prog_addr,   // word address
  input wire logic [15:0]       prog_data    // word data
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] stall_cnt_r;
  // -----------------------------------------------------------------
  // stall length counter, wide enough for the full programming time
  // -----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) stall_cnt_r <= 16'h0000;
    else stall_cnt_r <= cpu_stall ? stall_cnt_r + 16'h0001 : 16'h0000;
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_stall_bus; cpu_stall |-> !hreadyout; endproperty
  a_stall_bus: assert property (p_stall_bus) else $error("bus ready while stalled");
  property p_stall_len;
    $fell(cpu_stall) |-> (stall_cnt_r >= PROG_TIME_CYCLES && stall_cnt_r <= PROG_TIME_CYCLES + 2);
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_strobe_end; prog_strobe |-> !cpu_stall && $past(cpu_stall); endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe not at stall end");
  property p_one_word; prog_strobe |=> !prog_strobe [*2]; endproperty
  a_one_word: assert property (p_one_word) else $error("more than one word");
  property p_hold; !prog_strobe |-> $stable(prog_addr) && $stable(prog_data); endproperty
  a_hold: assert property (p_hold) else $error("word changed without strobe");
  property p_even; prog_addr[0] == 1'b0; endproperty
  a_even: assert property (p_even) else $error("word address odd");
  property p_rdata;
    $changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data changed unasked");
  c_prog: cover property (prog_strobe);
  c_stall: cover property ($rose(cpu_stall));
  c_read: cover property (hsel && htrans[1] && !hwrite && hready);
endmodule // flash_word_program_seq_sva
bind flash_word_program_seq flash_word_program_seq_sva #(.PROG_TIME_CYCLES(PROG_TIME_CYCLES))
  u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .cpu_stall(cpu_stall), .prog_strobe(prog_strobe), .prog_addr(prog_addr), .prog_data(prog_data));
`default_nettype wire

// ### test/cpu_bus_model.sv
// Purpose : software side, single AHB-Lite word transfers
// Assumes : one slave, its ready is the bus ready
// Notes   : waits on ready with no cycle count of its own
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        hclk,   // system clock
  input  wire logic        hready, // bus ready
  input  wire logic [31:0] hrdata, // read data
  output logic             hsel,   // select
  output logic [31:0]      haddr,  // address
  output logic [1:0]       htrans, // transfer type
  output logic             hwrite, // write
  output logic [2:0]       hsize,  // always word
  output logic [31:0]      hwdata  // write data
);
  // idle bus from time zero
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
  end
  // one transfer; held until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// ### test/flash_word_program_seq_test.sv
// Purpose : self-checking bench of the single-word program sequencer
// Assumes : programming time cut to 8 cycles
// Notes   : programmed words are queued and checked at each strobe
`timescale 1ns/100ps
`default_nettype none
module flash_word_program_seq_test
  import flash_word_pkg::*;
;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel, hwrite, hreadyout, hresp, cpu_stall, prog_strobe;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr, hwdata, hrdata, rd, seed;
  logic [ADDR_W-1:0] prog_addr;
  logic [15:0]       prog_data;
  logic [36:0]       exp_q[$];
  int                miscompares = 0;
  int                comparisons = 0;
  int                cyc = 0;
  // -----------------------------------------------------------------
  // clock, parts
  // -----------------------------------------------------------------
  initial
  begin
    forever #2.5 hclk = ~hclk;
  end
  cpu_bus_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  flash_word_program_seq #(.PROG_TIME_CYCLES(8)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_stall(cpu_stall), .prog_strobe(prog_strobe),
    .prog_addr(prog_addr), .prog_data(prog_data));
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [36:0] got, input logic [36:0] exp, input logic [36:0] mask);
    comparisons++;
    if ((got & mask) !== (exp & mask))
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, rd);
  endtask
  // fault 0 good, 1 keys reversed, 2 chain broken, 3 no write enable, 4 no word enable
  task automatic word(input logic [ADDR_W-1:0] a, input logic [15:0] d, input int bad);
    logic [31:0] ctl;
    ctl = (bad == 3) ? 32'h4 : (bad == 4) ? 32'h2 : 32'h6;
    wr(OFS_TABLE_POINTER, 32'(a));
    wr(OFS_TABLE_LATCH, {24'h0, d[7:0]});
    wr(OFS_TABLE_WRITE, 32'h1);
    wr(OFS_TABLE_LATCH, {24'h0, d[15:8]});
    wr(OFS_TABLE_WRITE, 32'h0);
    m.xfer(1'b0, OFS_HOLD_DATA, 32'h0, rd);
    cmp(37'(rd), 37'(d), 37'hFFFF);
    wr(OFS_MEM_CONTROL, ctl); // enable bits per fault, write start clear
    wr(OFS_UNLOCK_KEY, 32'(bad == 1 ? KEY_SECOND : KEY_FIRST));
    if (bad == 2) wr(OFS_TABLE_LATCH, 32'h0);
    wr(OFS_UNLOCK_KEY, 32'(bad == 1 ? KEY_FIRST : KEY_SECOND));
    if (bad == 0) exp_q.push_back({a, d});
    wr(OFS_MEM_CONTROL, ctl | 32'h1);
    m.xfer(1'b0, OFS_MEM_CONTROL, 32'h0, rd);
    cmp(37'(rd[BIT_WRITE_ERROR]), 37'(bad != 0), 37'h1);
    wr(OFS_MEM_CONTROL, 32'h0);
  endtask
  task automatic finish_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // checking and main sequence
  // -----------------------------------------------------------------
  // each strobe takes the oldest expected word; a strobe with none is a fault
  always @(negedge hclk)
    if (prog_strobe === 1'b1)
      cmp({prog_addr, prog_data}, exp_q.size() ? exp_q.pop_front() : 37'h1FFFFFFFFF,
          37'h1FFFFFFFFF);
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // good words before the first and after the last faulty one, so recovery is seen too
  // every random target counts as an erased location
  initial
  begin
    seed = 32'h51FC3B26;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      word(ADDR_W'(next_rand()) & ~21'h1, 16'(next_rand()), i % 5);
    repeat (4) @(posedge hclk);
    cmp(37'(exp_q.size()), 37'h0, 37'h1FFFFFFFFF);
    finish_test();
  end
endmodule // flash_word_program_seq_test
`default_nettype wire
